// [hdl/apm_defs.svh]
// constants of the converter power-mode controller
// assumes inclusion by bare name from the package and the design files
`ifndef APM_DEFS_SVH
`define APM_DEFS_SVH

// ----------------------------------------------------------------
// register map (byte addresses on the apb bus)
// ----------------------------------------------------------------
`define APM_ADDR_W 12
`define APM_ADDR_CTRL 12'h000
`define APM_ADDR_STATUS 12'h004
`define APM_ADDR_RESULT 12'h008
`define APM_ADDR_LSB 2

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define APM_CTRL_BIPOLAR 0
`define APM_CTRL_RST 1'b0
`define APM_ST_LOWPWR 0
`define APM_ST_HWDOWN 1
`define APM_ST_BUSY 2
`define APM_ST_INTMODE 3
`define APM_ST_REFON 4
`define APM_ST_VALID 5
`define APM_ST_STROBE 6

// ----------------------------------------------------------------
// codes and reset values
// ----------------------------------------------------------------
`define APM_RES_W 8
`define APM_RES_ZERO 8'h00
`define APM_SIGN_FLIP 8'h80
`define APM_MODE_INT 1'b0
`define APM_STROBE_RST 1'b1
`define APM_BITCNT_W 3
`define APM_BIT_LAST 3'h7
`define APM_BIT_FIRST 3'h1

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define APM_CLK_NS 8
`define APM_INT_CLK_NS 2500
`define APM_INT_DIV (`APM_INT_CLK_NS / `APM_CLK_NS)
`define APM_DIV_W 12

`endif

// [hdl/apm_pkg.sv]
// types shared by the converter power-mode controller
// assumes apm_defs.svh on the include path
`include "apm_defs.svh"

package apm_pkg;

  // ----------------------------------------------------------------
  // power states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {APM_IDLE, APM_CONV, APM_SWPD, APM_HWPD} apm_pwr_e;

  // ----------------------------------------------------------------
  // serial control byte, msb first on the wire
  // ----------------------------------------------------------------
  typedef struct packed {
    logic startBit;
    logic [4:0] select;
    logic powerSelect;
    logic clockMode;
  } apm_ctlbyte_s;

  // ----------------------------------------------------------------
  // apb request and answer
  // ----------------------------------------------------------------
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [`APM_ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } apm_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apm_apb_rsp_s;

endpackage : apm_pkg

// [hdl/apm_sar.sv]
// successive-approximation sequencer, one decision per step
// assumes step and compare come from logic on the same clock
`timescale 1ns/1ps
`include "apm_defs.svh"

module apm_sar #(
  parameter int WIDTH = `APM_RES_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // control
  input wire logic start,
  input wire logic abort,
  input wire logic step,
  input wire logic cmpHigh,
  // results
  output logic [WIDTH-1:0] trialCode,
  output logic [WIDTH-1:0] result,
  output logic busy,
  output logic done
);

  logic [WIDTH-1:0] trial_reg, trial_next;
  logic [WIDTH-1:0] mask_reg, mask_next;
  logic [WIDTH-1:0] res_reg;
  logic busy_reg, done_reg;
  logic [WIDTH-1:0] decided;
  logic lastStep;

  // ----------------------------------------------------------------
  // bit decision: keep the trial bit when the input is above it
  // ----------------------------------------------------------------
  assign decided = cmpHigh ? trial_reg : (trial_reg & ~mask_reg);
  assign lastStep = mask_reg[0];
  assign trial_next = decided | (mask_reg >> 1);
  assign mask_next = mask_reg >> 1;

  always_ff @(posedge clk) begin
    if (!rstn || abort) begin
      trial_reg <= '0;
      mask_reg <= '0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else if (start && !busy_reg) begin
      trial_reg <= {1'b1, {(WIDTH-1){1'b0}}};
      mask_reg <= {1'b1, {(WIDTH-1){1'b0}}};
      busy_reg <= 1'b1;
      done_reg <= 1'b0;
    end else if (busy_reg && step) begin
      trial_reg <= lastStep ? decided : trial_next;
      mask_reg <= mask_next;
      busy_reg <= !lastStep;
      done_reg <= lastStep;
    end else begin
      done_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      res_reg <= '0;
    end else if (busy_reg && step && lastStep && !abort) begin
      res_reg <= decided;
    end
  end

  assign trialCode = trial_reg;
  assign result = res_reg;
  assign busy = busy_reg;
  assign done = done_reg;

endmodule : apm_sar

// [hdl/apm_power_ctrl.sv]
// power-mode control of an 8-bit serial converter, apb register slave
// assumes sclk, csn and din from a serial master; shutdown pin sensed
// as two levels (low, floating) by the pad
//
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "apm_defs.svh"

// What this block does
// - after reset, unless shut down, conversions use the internal clock
// - strobe high after reset; first one on din with csn low starts
// - serial output shifts only zeros until a first conversion ends
// - power-select bit acts only while shutdown pin is not low
// - shutdown pin low powers the converter down at once, always
// - software power-down waits for the running conversion to finish
// - in either clock mode the serial port receives during software power-down, not during pin power-down
// - a start bit wakes the converter from software power-down
// - power-select one stays awake, zero sleeps after that conversion
// - pin high on, floating on with reference, low off
// - shutdown pin low abandons a running conversion immediately
// - result is an 8-bit binary code over 256 equal steps
// - clock-mode bit picks serial or internal conversion clock
// - unipolar straight binary, bipolar two's complement, msb first
module apm_power_ctrl #(
  parameter int INT_DIV = `APM_INT_DIV,
  parameter int RES_W = `APM_RES_W
) (
  // system clock and reset
  input wire logic clk,
  input wire logic rstn,
  // apb slave
  input apm_pkg::apm_apb_req_s apbReq,
  output apm_pkg::apm_apb_rsp_s apbRsp,
  // serial link
  input wire logic sclk,
  input wire logic csn,
  input wire logic din,
  output logic dout,
  output logic doutOe,
  output logic conversionStrobe,
  output logic conversionStrobeOe,
  // shutdown pin sense
  input wire logic shutdownPinLow,
  input wire logic shutdownPinFloat,
  // analog side
  input wire logic cmpHigh,
  output logic [RES_W-1:0] trialCode,
  output logic converterOn,
  output logic refEnable
);
  import apm_pkg::*;

  // ----------------------------------------------------------------
  // pin and cross-domain synchronisers into clk
  // ----------------------------------------------------------------
  logic lowS1_reg, lowS2_reg, fltS1_reg, fltS2_reg, csnS1_reg, csnS2_reg;
  logic startT1_reg, startT2_reg, startT3_reg;
  logic byteT1_reg, byteT2_reg, byteT3_reg;
  logic stepT1_reg, stepT2_reg, stepT3_reg;

  always_ff @(posedge clk) begin
    lowS1_reg <= shutdownPinLow;
    lowS2_reg <= lowS1_reg;
    fltS1_reg <= shutdownPinFloat;
    fltS2_reg <= fltS1_reg;
    csnS1_reg <= csn;
    csnS2_reg <= csnS1_reg;
  end

  logic startTog_reg, byteTog_reg, stepTog_reg;
  always_ff @(posedge clk) begin
    startT1_reg <= startTog_reg;
    startT2_reg <= startT1_reg;
    startT3_reg <= startT2_reg;
    byteT1_reg <= byteTog_reg;
    byteT2_reg <= byteT1_reg;
    byteT3_reg <= byteT2_reg;
    stepT1_reg <= stepTog_reg;
    stepT2_reg <= stepT1_reg;
    stepT3_reg <= stepT2_reg;
  end

  wire startEv = startT2_reg ^ startT3_reg;
  wire byteEv = byteT2_reg ^ byteT3_reg;
  wire extStep = stepT2_reg ^ stepT3_reg;
  wire shdnLow = lowS2_reg;

  // ----------------------------------------------------------------
  // power state machine
  // ----------------------------------------------------------------
  apm_pwr_e state_reg, state_next;
  apm_ctlbyte_s byte_reg;
  logic extMode_reg, powerSel_reg, strobe_reg, valid_reg, bipolar_reg;
  logic [RES_W-1:0] result_reg;
  logic [`APM_DIV_W-1:0] div_reg;
  logic sarBusy, sarDone;
  logic [RES_W-1:0] sarResult;

  wire intTick = (div_reg == `APM_DIV_W'(INT_DIV - 1));
  wire sarStep = extMode_reg ? extStep : intTick;
  wire acceptByte = byteEv && byte_reg.startBit &&
                    (state_reg == APM_IDLE || state_reg == APM_SWPD);
  wire sarStart = acceptByte && !shdnLow;
  wire byteExt = byte_reg.clockMode;
  wire [RES_W-1:0] coded = bipolar_reg ?
                           (sarResult ^ `APM_SIGN_FLIP) : sarResult;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      APM_IDLE: begin
        if (sarStart) begin
          state_next = APM_CONV;
        end
      end
      APM_CONV: begin
        if (sarDone) begin
          state_next = powerSel_reg ? APM_IDLE : APM_SWPD;
        end
      end
      APM_SWPD: begin
        if (sarStart) begin
          state_next = APM_CONV;
        end else if (startEv) begin
          state_next = APM_IDLE;
        end
      end
      APM_HWPD: begin
        state_next = APM_IDLE;
      end
      default: begin
        state_next = APM_IDLE;
      end
    endcase
    if (shdnLow) begin
      state_next = APM_HWPD;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_reg <= APM_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // mode bits latch with each control byte that starts a conversion
  always_ff @(posedge clk) begin
    if (!rstn) begin
      extMode_reg <= `APM_MODE_INT;
      powerSel_reg <= 1'b1;
    end else if (sarStart) begin
      extMode_reg <= byteExt;
      powerSel_reg <= byte_reg.powerSelect;
    end
  end

  // internal conversion clock divider
  always_ff @(posedge clk) begin
    if (!rstn || intTick || !sarBusy) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + `APM_DIV_W'(1);
    end
  end

  apm_sar #(
    .WIDTH(RES_W)
  ) u_sar (
    .clk(clk),
    .rstn(rstn),
    .start(sarStart),
    .abort(shdnLow),
    .step(sarStep),
    .cmpHigh(cmpHigh),
    .trialCode(trialCode),
    .result(sarResult),
    .busy(sarBusy),
    .done(sarDone)
  );

  // result register, coded for the input mode
  always_ff @(posedge clk) begin
    if (!rstn) begin
      result_reg <= `APM_RES_ZERO;
      valid_reg <= 1'b0;
    end else if (sarDone && !shdnLow) begin
      result_reg <= coded;
      valid_reg <= 1'b1;
    end
  end

  // strobe low while converting, high otherwise
  always_ff @(posedge clk) begin
    if (!rstn) begin
      strobe_reg <= `APM_STROBE_RST;
    end else begin
      strobe_reg <= !(state_next == APM_CONV);
    end
  end

  assign conversionStrobe = strobe_reg;
  assign conversionStrobeOe = !extMode_reg || !csnS2_reg;
  assign converterOn = (state_reg == APM_IDLE) || (state_reg == APM_CONV);
  assign refEnable = fltS2_reg && !shdnLow;

  // ----------------------------------------------------------------
  // apb slave: decode in setup, answer in the first access cycle
  // ----------------------------------------------------------------
  logic [31:0] rdata_reg;
  logic err_reg;
  wire setup = apbReq.psel && !apbReq.penable;
  wire access = apbReq.psel && apbReq.penable;
  wire hitCtrl = (apbReq.paddr == `APM_ADDR_CTRL);
  wire hitStatus = (apbReq.paddr == `APM_ADDR_STATUS);
  wire hitResult = (apbReq.paddr == `APM_ADDR_RESULT);
  wire mapped = hitCtrl || hitStatus || hitResult;
  wire [31:0] statusWord = {25'h0000000, strobe_reg, valid_reg,
                            refEnable, !extMode_reg, sarBusy,
                            (state_reg == APM_HWPD), !converterOn};
  wire [31:0] readMux = hitCtrl ? {31'h00000000, bipolar_reg} :
                        hitStatus ? statusWord :
                        hitResult ? {24'h000000, result_reg} : 32'h00000000;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdata_reg <= 32'h00000000;
      err_reg <= 1'b0;
    end else if (setup) begin
      rdata_reg <= apbReq.pwrite ? 32'h00000000 : readMux;
      err_reg <= !mapped;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      bipolar_reg <= `APM_CTRL_RST;
    end else if (access && apbReq.pwrite && hitCtrl) begin
      bipolar_reg <= apbReq.pwdata[`APM_CTRL_BIPOLAR];
    end
  end

  assign apbRsp.prdata = rdata_reg;
  assign apbRsp.pready = access;
  assign apbRsp.pslverr = access && err_reg;

  // ----------------------------------------------------------------
  // link domain on sclk: receive on rising, transmit on falling edge
  // ----------------------------------------------------------------
  logic lrst1_reg, lrst2_reg, hwd1_reg, hwd2_reg;
  logic rxActive_reg;
  logic [`APM_BITCNT_W-1:0] rxCnt_reg;
  logic [RES_W-2:0] rxShift_reg;
  logic resT1_reg, resT2_reg, resT3_reg, resTog_reg;
  logic [RES_W-1:0] txShift_reg;
  logic haveRes_reg;
  wire hwDown = (state_reg == APM_HWPD);

  always_ff @(posedge sclk) begin
    lrst1_reg <= rstn;
    lrst2_reg <= lrst1_reg;
    hwd1_reg <= hwDown;
    hwd2_reg <= hwd1_reg;
  end

  wire linkRstn = lrst2_reg;
  wire rxHold = !linkRstn || csn || hwd2_reg;

  // start-bit hunt, then seven more bits make the byte
  always_ff @(posedge sclk) begin
    if (rxHold) begin
      rxActive_reg <= 1'b0;
      rxCnt_reg <= '0;
    end else if (!rxActive_reg) begin
      rxActive_reg <= din;
      rxCnt_reg <= `APM_BIT_FIRST;
    end else begin
      rxCnt_reg <= rxCnt_reg + `APM_BITCNT_W'(1);
      rxActive_reg <= (rxCnt_reg != `APM_BIT_LAST);
    end
  end

  always_ff @(posedge sclk) begin
    if (!linkRstn) begin
      rxShift_reg <= '0;
      startTog_reg <= 1'b0;
      byteTog_reg <= 1'b0;
      byte_reg <= '0;
    end else if (!rxHold && !rxActive_reg && din) begin
      rxShift_reg <= {{(RES_W-2){1'b0}}, 1'b1};
      startTog_reg <= !startTog_reg;
    end else if (!rxHold && rxActive_reg) begin
      rxShift_reg <= {rxShift_reg[RES_W-3:0], din};
      if (rxCnt_reg == `APM_BIT_LAST) begin
        byte_reg <= {rxShift_reg, din};
        byteTog_reg <= !byteTog_reg;
      end
    end
  end

  // result handover toggle, flipped on the same clock edge that writes result_reg
  always_ff @(posedge clk) begin
    if (!rstn) begin
      resTog_reg <= 1'b0;
    end else if (sarDone && !shdnLow) begin
      resTog_reg <= !resTog_reg;
    end
  end

  always_ff @(negedge sclk) begin
    resT1_reg <= resTog_reg;
    resT2_reg <= resT1_reg;
    resT3_reg <= resT2_reg;
  end

  wire resEv = resT2_reg ^ resT3_reg;

  // transmitter never gated by software power-down
  always_ff @(negedge sclk) begin
    if (!linkRstn) begin
      txShift_reg <= `APM_RES_ZERO;
      haveRes_reg <= 1'b0;
      stepTog_reg <= 1'b0;
    end else begin
      stepTog_reg <= csn ? stepTog_reg : !stepTog_reg;
      if (resEv) begin
        txShift_reg <= result_reg;
        haveRes_reg <= 1'b1;
      end else if (!csn) begin
        txShift_reg <= {txShift_reg[RES_W-2:0], 1'b0};
      end
    end
  end

  assign dout = txShift_reg[RES_W-1];
  assign doutOe = !csn;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_reset_intmode: assert property (@(posedge clk)
    !rstn |=> !extMode_reg)
    else $error("clock mode not internal after reset");

  chk_reset_strobe: assert property (@(posedge clk)
    !rstn |=> conversionStrobe)
    else $error("strobe not high after reset");

  chk_hw_abort: assert property (@(posedge clk) disable iff (!rstn)
    shdnLow |=> state_reg == APM_HWPD && !sarBusy)
    else $error("shutdown did not abort conversion");

  chk_ref_state: assert property (@(posedge clk) disable iff (!rstn)
    shdnLow |-> !refEnable && !(state_reg == APM_IDLE && $past(shdnLow)))
    else $error("reference or converter on in shutdown");

  chk_sleep_after: assert property (@(posedge clk) disable iff (!rstn)
    sarDone && !powerSel_reg && !shdnLow |=> state_reg == APM_SWPD)
    else $error("no power-down after single conversion");

  chk_finish_first: assert property (@(posedge clk) disable iff (!rstn)
    state_reg == APM_CONV && !sarDone && !shdnLow
    |=> state_reg == APM_CONV)
    else $error("left conversion before it finished");

  chk_wake_start: assert property (@(posedge clk) disable iff (!rstn)
    state_reg == APM_SWPD && startEv && !sarStart && !shdnLow
    |=> state_reg == APM_IDLE)
    else $error("start bit did not wake converter");

  chk_release_idle: assert property (@(posedge clk) disable iff (!rstn)
    state_reg == APM_HWPD && !shdnLow
    |=> state_reg == APM_IDLE && !sarBusy)
    else $error("shutdown release not to idle");

  chk_code_mode: assert property (@(posedge clk) disable iff (!rstn)
    sarDone && !shdnLow |=> result_reg[RES_W-1] ==
    ($past(sarResult[RES_W-1]) ^ $past(bipolar_reg)))
    else $error("result coding wrong for input mode");

  chk_first_zero: assert property (@(negedge sclk) disable iff (!linkRstn)
    !haveRes_reg |-> txShift_reg == `APM_RES_ZERO)
    else $error("nonzero output before first conversion");

endmodule : apm_power_ctrl

// [verification/apm_serial_master.sv]
// serial master model driving the converter's link
// assumes dout moves on falling sclk; sclk stands still between frames
`timescale 1ns/1ps

module apm_serial_master #(
  parameter int HALF_NS = 16,
  parameter int SETTLE_NS = 2000
) (
  // link
  output logic sclk,
  output logic csn,
  output logic din,
  input wire logic dout
);
  logic refReady;

  initial begin
    sclk = 1'b0;
    csn = 1'b1;
    din = 1'b0;
    refReady = 1'b0;
    #(SETTLE_NS) refReady = 1'b1;
  end

  // pulses with csn high, only to carry reset into the link side and then release it
  task automatic pulses(input int n);
    repeat (n) begin
      #(HALF_NS) sclk = 1'b1;
      #(HALF_NS) sclk = 1'b0;
    end
  endtask : pulses

  // send the top n bits of tx msb first, capture dout at each rise
  task automatic xfer(input logic [31:0] tx, input int n,
                      output logic [31:0] rx);
    rx = '0;
    wait (refReady === 1'b1);
    #3 csn = 1'b0;
    for (int i = 0; i < n; i++) begin
      din = tx[31-i];
      #(HALF_NS) rx = {rx[30:0], dout};
      sclk = 1'b1;
      #(HALF_NS) sclk = 1'b0;
    end
    #(HALF_NS) csn = 1'b1;
    // released line does not keep its last level
    din = ~din;
  endtask : xfer
endmodule : apm_serial_master

// [verification/tb_adc_power_mode_control.sv]
// self-checking bench of the converter power-mode controller
// assumes apm_pkg, apm_defs.svh and apm_serial_master compiled first
`timescale 1ns/1ps
`include "apm_defs.svh"

module tb_adc_power_mode_control;
  import apm_pkg::*;

  // ----------------------------------------------------------------
  // design, serial master and comparator
  // ----------------------------------------------------------------
  typedef struct packed {
    logic flt, bip, pwr, ext;
    logic [7:0] v, res;
    logic low;
  } apm_row_s;
  localparam apm_row_s ROWS [6] = '{
    '{1'b0, 1'b0, 1'b1, 1'b0, 8'hC5, 8'hC5, 1'b0},
    '{1'b1, 1'b0, 1'b0, 1'b0, 8'h80, 8'h80, 1'b1},
    '{1'b0, 1'b1, 1'b1, 1'b1, 8'h3A, 8'hBA, 1'b0},
    '{1'b1, 1'b0, 1'b1, 1'b1, 8'hFF, 8'hFF, 1'b0},
    '{1'b0, 1'b1, 1'b0, 1'b0, 8'h81, 8'h01, 1'b1},
    '{1'b0, 1'b0, 1'b1, 1'b1, 8'h00, 8'h00, 1'b0}};
  logic clk = 1'b0;
  logic rstn = 1'b0;
  apm_apb_req_s apbReq = '0;
  apm_apb_rsp_s apbRsp;
  logic sclk, csn, din, dout, strobe, strobeOe, conOn, refEn, dOe;
  logic pinLow = 1'b0;
  logic pinFloat = 1'b0;
  logic [7:0] vin = 8'h00;
  logic [7:0] trial;
  wire cmpHigh = (vin >= trial);
  int n_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [31:0] rd, rx, rx0;
  logic err;

  always #4 clk = ~clk;

  apm_power_ctrl #(.INT_DIV(40), .RES_W(8)) DUT (
    .clk(clk), .rstn(rstn), .apbReq(apbReq), .apbRsp(apbRsp),
    .sclk(sclk), .csn(csn), .din(din), .dout(dout), .doutOe(dOe),
    .conversionStrobe(strobe), .conversionStrobeOe(strobeOe),
    .shutdownPinLow(pinLow), .shutdownPinFloat(pinFloat),
    .cmpHigh(cmpHigh), .trialCode(trial), .converterOn(conOn),
    .refEnable(refEn));
  apm_serial_master master (.sclk(sclk), .csn(csn), .din(din),
    .dout(dout));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp, got);
    num_checks++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd);
    @(posedge clk);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a,
                pwdata: wd};
    @(posedge clk);
    apbReq.penable <= 1'b1;
    do @(posedge clk); while (apbRsp.pready !== 1'b1);
    rd = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq <= '0;
  endtask : apb

  task automatic wait_idle();
    for (int i = 0; i < 300; i++) begin
      apb(1'b0, `APM_ADDR_STATUS, '0);
      if (rd[`APM_ST_BUSY] === 1'b0) break;
    end
  endtask : wait_idle

  task automatic do_reset();
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    master.pulses(3);
    @(posedge clk);
    rstn <= 1'b1;
    master.pulses(3);
  endtask : do_reset

  // result may start a few clocks into the frame
  function automatic logic seen(input logic [31:0] r, input logic [7:0] v);
    logic ok;
    ok = 1'b0;
    for (int k = 0; k <= 24; k++) if (r === ({v, 24'h0} >> k)) ok = 1'b1;
    return ok;
  endfunction : seen

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_errors++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    do_reset();
    foreach (ROWS[i]) begin
      apb(1'b1, `APM_ADDR_CTRL, {31'h0, ROWS[i].bip});
      vin <= ROWS[i].v;
      pinFloat <= ROWS[i].flt;
      master.xfer({2'b00, 1'b1, 5'h00, ROWS[i].pwr, ROWS[i].ext, 22'h0},
                  32, rx0);
      wait_idle();
      apb(1'b0, `APM_ADDR_RESULT, '0);
      check("result", {24'h0, ROWS[i].res}, rd);
      apb(1'b0, `APM_ADDR_STATUS, '0);
      check("status", {25'h0, 2'b11, ROWS[i].flt, !ROWS[i].ext, 2'b00,
            ROWS[i].low}, rd);
      check("refEnable", ROWS[i].flt, refEn);
      check("converterOn", !ROWS[i].low, conOn);
      master.xfer('0, 32, rx);
      // serial-clocked conversions shift the result out in their own frame
      check("dout", 1, seen(ROWS[i].ext ? rx0 : rx, ROWS[i].res));
    end
    do_reset();
    check("strobe", 1, strobe);
    check("strobeOe", 1, strobeOe);
    check("doutOe", 0, dOe);
    apb(1'b0, `APM_ADDR_STATUS, '0);
    check("status", 32'h48, rd);
    apb(1'b0, `APM_ADDR_RESULT, '0);
    check("result", 0, rd);
    master.xfer('0, 32, rx);
    check("dout", 0, rx);
    apb(1'b1, 12'h00C, 32'hFFFFFFFF);
    check("pslverr", 1, err);
    apb(1'b0, 12'h00C, '0);
    check("unmapped", 0, rd);
    apb(1'b1, `APM_ADDR_STATUS, 32'hFFFFFFFF);
    apb(1'b0, `APM_ADDR_STATUS, '0);
    check("status ro", 32'h48, rd);
    vin <= 8'h9C;
    master.xfer({2'b00, 8'h80, 22'h0}, 10, rx);
    check("strobe busy", 0, strobe);
    check("converterOn busy", 1, conOn);
    wait_idle();
    check("converterOn sleep", 0, conOn);
    master.xfer(32'h20000000, 3, rx);
    repeat (8) @(posedge clk);
    check("converterOn wake", 1, conOn);
    vin <= 8'h55;
    master.xfer({2'b00, 8'h82, 22'h0}, 10, rx);
    @(posedge clk);
    pinLow <= 1'b1;
    repeat (4) @(posedge clk);
    check("converterOn down", 0, conOn);
    apb(1'b0, `APM_ADDR_STATUS, '0);
    check("status down", 3'b011, rd[2:0]);
    master.xfer({2'b00, 8'h82, 22'h0}, 10, rx);
    check("converterOn held", 0, conOn);
    @(posedge clk);
    pinLow <= 1'b0;
    repeat (5) @(posedge clk);
    check("converterOn up", 1, conOn);
    apb(1'b0, `APM_ADDR_RESULT, '0);
    check("result kept", 32'h9C, rd);
    master.xfer({2'b00, 8'h82, 22'h0}, 32, rx);
    wait_idle();
    apb(1'b0, `APM_ADDR_RESULT, '0);
    check("result new", 32'h55, rd);
    stop_test();
  end
endmodule : tb_adc_power_mode_control
